// *** core/psrb_pkg.sv ***
// package of constants for the processor state register bank
package psrb_pkg;
    // ======================================================================
    // register selectors
    typedef enum logic [2:0] {
        PSRB_SEL_FPSTATE,
        PSRB_SEL_CYCLE,
        PSRB_SEL_TRAPSTATE,
        PSRB_SEL_IDENT,
        PSRB_SEL_PERFCTL
    } psrb_sel_t;

    // ======================================================================
    // fp state fields
    localparam int FP_CEXC_LSB  = 0;
    localparam int FP_CEXC_W    = 5;
    localparam int FP_AEXC_LSB  = 5;
    localparam int FP_FTT_LSB   = 14;
    localparam int FP_FTT_W     = 3;
    localparam int FP_REV_LSB   = 17;
    localparam int FP_REV_W     = 3;
    localparam int FP_FLUSH_BIT = 22;
    localparam int FP_TEM_LSB   = 23;
    localparam int FP_NXM_BIT   = 23;
    localparam logic [2:0] FP_FTT_NONE     = 3'h0;
    localparam logic [2:0] FP_FTT_IEEE     = 3'h1;
    localparam logic [2:0] FP_FTT_UNFIN    = 3'h2;
    localparam logic [2:0] FP_FTT_UNIMP    = 3'h3;
    localparam logic [4:0] FP_INEXACT_MASK = 5'h01;
    localparam logic [63:0] FP_RESET = 64'h0000_0000_0000_0000;

    // ======================================================================
    // cycle counter and trap state
    localparam int CYC_W          = 63;
    localparam int TS_CWP_LSB     = 0;
    localparam int TS_CWP_STORE_W = 3;
    localparam int TS_CWP_W       = 5;

    // ======================================================================
    // identification fields
    localparam int ID_MAKER_LSB = 48;
    localparam int ID_IMPL_LSB  = 32;
    localparam int ID_REV_LSB   = 24;
    localparam int ID_MAXTL_LSB = 8;
    localparam int ID_MAXWIN_LSB = 0;

    // ======================================================================
    // perf control fields
    localparam int PC_LOCK_BIT    = 0;
    localparam int PC_EVENT_SELECT_WRITE_INHIBIT_BIT    = 3;
    localparam int PC_SL_LSB      = 4;
    localparam int PC_SU_LSB      = 11;
    localparam int PC_EV_W        = 6;
    localparam int PC_SC_LSB      = 18;
    localparam int PC_NC_LSB      = 22;
    localparam int PC_OVERFLOW_WRITE_INHIBIT_BIT    = 26;
    localparam int PC_OVF_LSB     = 32;
    localparam int PC_OVF_W       = 8;
    localparam int PC_PAIRS       = 4;
    localparam logic [2:0] PC_NC_VALUE = 3'h3;
endpackage

// *** core/psrb_bank.sv ***
// processor state register bank accessed by the instruction pipeline
// Function
// - flush mode one zeroes denormals, signals inexact, maskable by inexact trap enable.
// - flush mode zero gives plain ieee behaviour, nothing flushed.
// - fpu revision field is a read-only implementation code.
// - current exception bits report last fp operate, absent ones cleared.
// - fp state loads set current exceptions from data, highest priority.
// - fp operate with no trap type takes fpu supplied exceptions.
// - fp operate with ieee trap sets exactly the one indicated bit.
// - unfinished, unimplemented or other cases leave current exceptions unchanged.
// - trap enable, current and accrued exception fields held in hardware.
// - cycle counter portion is 63 bits wide.
// - cycle counter read returns value at execute, not commit.
// - only window pointer bits 2:0 stored; bits 4:3 ignore writes, read zero.
// - identification revision field in bits 31:24, increasing with releases.
// - maker field bits 63:48 holds 8-bit maker code, upper byte zero.
// - user mode with lock set makes perf control read and write privileged faults.
// - user mode, lock clear: reads pass, writes fault only when setting lock.
// - overflow flags at 39:32, eight pair flags, rest zero, write zero clears.
// - overflow write inhibit is write-only, protects flags for that write.
// - counter pair count reads constant 3, meaning four pairs.
// - pair select chooses written pair and the exposed pair; reads return it.
// - event select inhibit is write-only; set keeps selections, reads show them.
// - user access lock at bit 0 gates user access to perf control.
// - software may set overflow flags; such sets raise no overflow interrupt.
`timescale 1ns/1ps
module psrb_bank #(
    parameter int          PAIRS      = 4,
    parameter logic [2:0]  FPU_REV    = 3'h0,   // arbitrary value
    parameter logic [7:0]  MAKER_CODE = 8'h5a,  // arbitrary value
    parameter logic [15:0] IMPL_CODE  = 16'h0042, // arbitrary value
    parameter logic [7:0]  CHIP_REV   = 8'h01,  // arbitrary value
    parameter logic [7:0]  MAX_TL     = 8'h05,
    parameter logic [4:0]  MAX_WIN    = 5'h07
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        supervisor_mode_bit,
    input  wire logic        rd_en,
    input  wire logic [2:0]  rd_sel,
    output logic [63:0]      rd_data,
    output logic             rd_priv_fault,
    input  wire logic        wr_en,
    input  wire logic [2:0]  wr_sel,
    input  wire logic [63:0] wr_data,
    output logic             wr_priv_fault,
    input  wire logic        fp_load_commit,
    input  wire logic        fp_op_commit,
    input  wire logic [2:0]  fp_op_trap_type,
    input  wire logic [4:0]  fp_op_cexc,
    input  wire logic [2:0]  fp_op_trap_bit,
    input  wire logic [PAIRS*2-1:0] ovf_event,
    output logic             flush_denormal_mode,
    output logic             fp_inexact_trap_en,
    output logic [2:0]       counter_pair_select,
    output logic [5:0]       upper_event_select,
    output logic [5:0]       lower_event_select
);
    // ======================================================================
    // parameter check
    initial begin
        if (PAIRS != psrb_pkg::PC_PAIRS) begin
            $error("psrb_bank: only four counter pairs are supported");
        end
    end

    // ======================================================================
    // state
    logic [63:0] fp_state;
    logic [psrb_pkg::CYC_W-1:0] cycle_count;
    logic        cycle_npt;
    logic [psrb_pkg::TS_CWP_STORE_W-1:0] ts_cwp;
    logic [63:psrb_pkg::TS_CWP_W] ts_upper;
    logic        user_access_lock;
    logic [7:0]  overflow_flags;
    logic [2:0]  pair_sel;
    logic [5:0]  su_sel [PAIRS];
    logic [5:0]  sl_sel [PAIRS];

    // ======================================================================
    // access decode
    wire user_mode  = !supervisor_mode_bit;
    wire rd_perf    = rd_en && (rd_sel == 3'(psrb_pkg::PSRB_SEL_PERFCTL));
    wire wr_perf    = wr_en && (wr_sel == 3'(psrb_pkg::PSRB_SEL_PERFCTL));
    wire rd_fault   = rd_perf && user_mode && user_access_lock;
    wire wr_fault   = wr_perf && user_mode && (user_access_lock || wr_data[psrb_pkg::PC_LOCK_BIT]);
    wire wr_perf_ok = wr_perf && !wr_fault;
    wire wr_fp      = wr_en && (wr_sel == 3'(psrb_pkg::PSRB_SEL_FPSTATE));
    wire wr_cyc     = wr_en && (wr_sel == 3'(psrb_pkg::PSRB_SEL_CYCLE));
    wire wr_ts      = wr_en && (wr_sel == 3'(psrb_pkg::PSRB_SEL_TRAPSTATE));
    wire [2:0] wr_pair = wr_data[psrb_pkg::PC_SC_LSB +: 3];
    wire ev_update  = wr_perf_ok && !wr_data[psrb_pkg::PC_EVENT_SELECT_WRITE_INHIBIT_BIT];
    wire ovf_write  = wr_perf_ok && !wr_data[psrb_pkg::PC_OVERFLOW_WRITE_INHIBIT_BIT];

    // ======================================================================
    // current exception update, in priority order
    logic [4:0] next_cexc;
    logic [4:0] one_hot_trap;
    always_comb begin
        one_hot_trap = 5'h00;
        one_hot_trap[fp_op_trap_bit] = 1'b1;
        next_cexc = fp_state[psrb_pkg::FP_CEXC_LSB +: psrb_pkg::FP_CEXC_W];
        if (fp_load_commit && wr_fp) begin
            next_cexc = wr_data[psrb_pkg::FP_CEXC_LSB +: psrb_pkg::FP_CEXC_W];
        end else if (fp_op_commit && fp_op_trap_type == psrb_pkg::FP_FTT_NONE) begin
            next_cexc = fp_op_cexc;
        end else if (fp_op_commit && fp_op_trap_type == psrb_pkg::FP_FTT_IEEE) begin
            next_cexc = one_hot_trap;
        end
        // unfinished, unimplemented and idle leave it as is
    end

    // accrued bits gather untrapped exceptions, trap type recorded per operate
    wire fp_op_clean = fp_op_commit && fp_op_trap_type == psrb_pkg::FP_FTT_NONE && !(fp_load_commit && wr_fp);
    logic [63:0] next_fp;
    always_comb begin
        next_fp = fp_state;
        if (wr_fp) begin
            next_fp = wr_data;
        end else if (fp_op_commit) begin
            next_fp[psrb_pkg::FP_FTT_LSB +: psrb_pkg::FP_FTT_W] = fp_op_trap_type;
        end
        if (fp_op_clean) begin
            next_fp[psrb_pkg::FP_AEXC_LSB +: psrb_pkg::FP_CEXC_W] =
                fp_state[psrb_pkg::FP_AEXC_LSB +: psrb_pkg::FP_CEXC_W] | fp_op_cexc;
        end
        next_fp[psrb_pkg::FP_CEXC_LSB +: psrb_pkg::FP_CEXC_W] = next_cexc;
        next_fp[psrb_pkg::FP_REV_LSB +: psrb_pkg::FP_REV_W] = FPU_REV;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            fp_state <= psrb_pkg::FP_RESET;
        end else begin
            fp_state <= next_fp;
        end
    end

    // mode outputs drive the fpu datapath; flush replaces denormals and raises masked inexact
    assign flush_denormal_mode = fp_state[psrb_pkg::FP_FLUSH_BIT];
    assign fp_inexact_trap_en  = fp_state[psrb_pkg::FP_NXM_BIT];

    // ======================================================================
    // cycle counter and trap state
    always_ff @(posedge clk) begin
        if (rst) begin
            cycle_count <= '0;
            cycle_npt   <= 1'b0;
        end else if (wr_cyc) begin
            cycle_count <= wr_data[psrb_pkg::CYC_W-1:0];
            cycle_npt   <= wr_data[63];
        end else begin
            cycle_count <= cycle_count + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ts_cwp   <= '0;
            ts_upper <= '0;
        end else if (wr_ts) begin
            ts_cwp   <= wr_data[psrb_pkg::TS_CWP_STORE_W-1:0];
            ts_upper <= wr_data[63:psrb_pkg::TS_CWP_W];
        end
    end

    // ======================================================================
    // perf control state
    always_ff @(posedge clk) begin
        if (rst) begin
            user_access_lock <= 1'b0;
            pair_sel         <= 3'h0;
        end else if (wr_perf_ok) begin
            user_access_lock <= wr_data[psrb_pkg::PC_LOCK_BIT];
            pair_sel         <= wr_pair;
        end
    end

    // hardware overflow wins over a software clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            overflow_flags <= 8'h00;
        end else if (ovf_write) begin
            overflow_flags <= wr_data[psrb_pkg::PC_OVF_LSB +: psrb_pkg::PC_OVF_W] | ovf_event;
        end else begin
            overflow_flags <= overflow_flags | ovf_event;
        end
    end

    genvar gp;
    generate
        for (gp = 0; gp < PAIRS; gp++) begin : g_pair
            always_ff @(posedge clk) begin
                if (rst) begin
                    su_sel[gp] <= 6'h00;
                    sl_sel[gp] <= 6'h00;
                end else if (ev_update && wr_pair == 3'(gp)) begin
                    su_sel[gp] <= wr_data[psrb_pkg::PC_SU_LSB +: psrb_pkg::PC_EV_W];
                    sl_sel[gp] <= wr_data[psrb_pkg::PC_SL_LSB +: psrb_pkg::PC_EV_W];
                end
            end
        end
    endgenerate

    // out-of-range selects show zero selections
    wire       sel_ok   = pair_sel < 3'(PAIRS);
    wire [1:0] sel_idx  = pair_sel[1:0];
    wire [5:0] cur_su   = sel_ok ? su_sel[sel_idx] : 6'h00;
    wire [5:0] cur_sl   = sel_ok ? sl_sel[sel_idx] : 6'h00;
    assign counter_pair_select = pair_sel;
    assign upper_event_select  = cur_su;
    assign lower_event_select  = cur_sl;

    // ======================================================================
    // read views
    wire [63:0] perf_view = {16'h0000, 8'h00, overflow_flags, 5'h00, 1'b0, 1'b0,
                             psrb_pkg::PC_NC_VALUE, 1'b0, pair_sel, 1'b0, cur_su,
                             1'b0, cur_sl, 1'b0, 2'b00, user_access_lock};
    wire [63:0] ident_view = {8'h00, MAKER_CODE, IMPL_CODE, CHIP_REV, 8'h00,
                              MAX_TL, 3'b000, MAX_WIN};
    wire [63:0] ts_view    = {ts_upper, 2'b00, ts_cwp};
    wire [63:0] cyc_view   = {cycle_npt, cycle_count};

    logic [63:0] next_rd;
    always_comb begin
        next_rd = 64'h0000_0000_0000_0000;
        if (rd_sel == 3'(psrb_pkg::PSRB_SEL_FPSTATE)) begin
            next_rd = fp_state;
        end else if (rd_sel == 3'(psrb_pkg::PSRB_SEL_CYCLE)) begin
            next_rd = cyc_view;
        end else if (rd_sel == 3'(psrb_pkg::PSRB_SEL_TRAPSTATE)) begin
            next_rd = ts_view;
        end else if (rd_sel == 3'(psrb_pkg::PSRB_SEL_IDENT)) begin
            next_rd = ident_view;
        end else if (rd_sel == 3'(psrb_pkg::PSRB_SEL_PERFCTL) && !rd_fault) begin
            next_rd = perf_view;
        end
    end

    // read data latched at execute, so the counter value is the execute-time one
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data <= 64'h0000_0000_0000_0000;
        end else if (rd_en) begin
            rd_data <= next_rd;
        end
    end

    assign rd_priv_fault = rd_fault;
    assign wr_priv_fault = wr_fault;
endmodule

// *** bench/psrb_bank_asserts.sv ***
// port assertions for the processor state register bank
`timescale 1ns/1ps
module psrb_bank_asserts (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        supervisor_mode_bit,
    input wire logic        rd_en,
    input wire logic [2:0]  rd_sel,
    input wire logic [63:0] rd_data,
    input wire logic        rd_priv_fault,
    input wire logic        wr_en,
    input wire logic [2:0]  wr_sel,
    input wire logic [63:0] wr_data,
    input wire logic        wr_priv_fault,
    input wire logic [2:0]  counter_pair_select
);
    // ==========================================================
    // shadow of the lock, since the lock bit is not a port
    logic lock_q;
    wire  pc_rd = rd_en && rd_sel == psrb_pkg::PSRB_SEL_PERFCTL;
    wire  pc_wu = wr_en && wr_sel == psrb_pkg::PSRB_SEL_PERFCTL && !supervisor_mode_bit;
    wire  pc_wr = wr_en && wr_sel == psrb_pkg::PSRB_SEL_PERFCTL && !wr_priv_fault;
    wire  cy_rd = rd_en && rd_sel == psrb_pkg::PSRB_SEL_CYCLE;
    always_ff @(posedge clk) begin
        if (rst) lock_q <= 1'b0;
        else if (pc_wr) lock_q <= wr_data[0];
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    chk_rd_lock_fault: assert property (pc_rd && !supervisor_mode_bit |-> rd_priv_fault == lock_q)
        else $error("read fault wrong");
    chk_wr_lock_fault: assert property (pc_wu |-> wr_priv_fault == (lock_q | wr_data[0]))
        else $error("write fault wrong");
    chk_fault_reads_zero: assert property (pc_rd && rd_priv_fault |=> rd_data == 64'h0000_0000_0000_0000)
        else $error("faulted read not zero");
    chk_pc_fixed_bits: assert property (pc_rd && !rd_priv_fault |=> rd_data[24:22] == 3'h3
        && {rd_data[63:40], rd_data[26:25], rd_data[21], rd_data[17], rd_data[10], rd_data[3:1]} == 32'h0000_0000)
        else $error("perf control fixed bits wrong");
    chk_cwp_high_zero: assert property (rd_en && rd_sel == 3'h2 |=> rd_data[4:3] == 2'h0)
        else $error("window pointer high bits set");
    chk_maker_top_zero: assert property (rd_en && rd_sel == 3'h3 |=> rd_data[63:56] == 8'h00)
        else $error("maker upper byte set");
    chk_pair_select: assert property (pc_wr |=> counter_pair_select == $past(wr_data[20:18]))
        else $error("pair select not taken");
    chk_tick_step: assert property (cy_rd ##2 cy_rd |=> rd_data[62:0] == $past(rd_data[62:0], 2) + 63'h2)
        else $error("cycle reads not two apart");
endmodule
bind psrb_bank psrb_bank_asserts u_chk (.clk(clk), .rst(rst), .supervisor_mode_bit(supervisor_mode_bit),
    .rd_en(rd_en), .rd_sel(rd_sel), .rd_data(rd_data), .rd_priv_fault(rd_priv_fault), .wr_en(wr_en),
    .wr_sel(wr_sel), .wr_data(wr_data), .wr_priv_fault(wr_priv_fault), .counter_pair_select(counter_pair_select));

// *** bench/psrb_pipe_model.sv ***
// instruction pipeline model issuing accesses to the register bank
`timescale 1ns/1ps
module psrb_pipe_model (
    input  wire logic   clk,
    output logic        rd_en,
    output logic [2:0]  rd_sel,
    output logic        wr_en,
    output logic [2:0]  wr_sel,
    output logic [63:0] wr_data,
    output logic        fp_load_commit,
    output logic        fp_op_commit,
    output logic [2:0]  fp_op_trap_type,
    output logic [4:0]  fp_op_cexc,
    output logic [2:0]  fp_op_trap_bit
);
    // idle pipeline until the first request
    initial begin
        rd_en           = 1'b0;
        rd_sel          = 3'h0;
        wr_en           = 1'b0;
        wr_sel          = 3'h0;
        wr_data         = 64'h0000_0000_0000_0000;
        fp_load_commit  = 1'b0;
        fp_op_commit    = 1'b0;
        fp_op_trap_type = 3'h0;
        fp_op_cexc      = 5'h00;
        fp_op_trap_bit  = 3'h0;
    end
    // ==========================================================
    // requests, each held across exactly one sampling edge
    task automatic rd(input logic [2:0] s);
        @(posedge clk);
        rd_en <= 1'b1;
        rd_sel <= s;
        @(posedge clk);
        rd_en <= 1'b0;
        rd_sel <= ~s;
        #1;
    endtask
    // the select is passed through unchecked, so writes to selects naming no bank register are issued too
    task automatic req(input logic w, input logic [2:0] s, input logic [63:0] d, input logic l, input logic o,
                       input logic [2:0] t, input logic [4:0] c, input logic [2:0] b);
        @(posedge clk);
        wr_en <= w;
        wr_sel <= s;
        wr_data <= d;
        fp_load_commit <= l;
        fp_op_commit <= o;
        fp_op_trap_type <= t;
        fp_op_cexc <= c;
        fp_op_trap_bit <= b;
        @(posedge clk);
        wr_en <= 1'b0;
        wr_data <= ~d; // released data must not look valid
        fp_load_commit <= 1'b0;
        fp_op_commit <= 1'b0;
        #1;
    endtask
endmodule

// *** bench/processor_state_register_bank_tb.sv ***
// self-checking bench for the processor state register bank
`timescale 1ns/1ps
module processor_state_register_bank_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        sup;
    logic        rd_en, wr_en, ld, op, rdf, wrf, rpf, wpf, fl, te;
    logic [2:0]  rd_sel, wr_sel, ty, bt, sc;
    logic [4:0]  cx;
    logic [5:0]  su, sl;
    logic [7:0]  ovf;
    logic [63:0] rd_data, wr_data, t0;
    int          bad_count = 0;
    int          n_checks = 0;
    // ==========================================================
    // rows: select, written word, word read back
    localparam logic [2:0]  R_SEL [8] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h4, 3'h4, 3'h4, 3'h5};
    localparam logic [63:0] R_WD [8] = '{64'h0000_0000_0FCE_03FF, 64'hFFFF_FFFF_FFFF_FFFF, 64'hFFFF_FFFF_FFFF_FFFF,
        64'hFFFF_FFA5_0008_AAA0, 64'h0000_0000_0408_0008, 64'h0000_0000_0004_0008, 64'h0000_00FF_0008_0008,
        64'hFFFF_FFFF_FFFF_FFFF};
    localparam logic [63:0] R_EX [8] = '{64'h0000_0000_0FC0_03FF, 64'hFFFF_FFFF_FFFF_FFE7, 64'h003C_0011_0200_0507,
        64'h0000_00A5_00C8_AAA0, 64'h0000_00A5_00C8_AAA0, 64'h0000_0000_00C4_0000, 64'h0000_00FF_00C8_AAA0,
        64'h0000_0000_0000_0000};
    // identification codes below are arbitrary
    psrb_bank #(.MAKER_CODE(8'h3C), .IMPL_CODE(16'h0011), .CHIP_REV(8'h02)) u_dut (.clk(clk), .rst(rst),
        .supervisor_mode_bit(sup), .rd_en(rd_en), .rd_sel(rd_sel), .rd_data(rd_data), .rd_priv_fault(rdf),
        .wr_en(wr_en), .wr_sel(wr_sel), .wr_data(wr_data), .wr_priv_fault(wrf), .fp_load_commit(ld),
        .fp_op_commit(op), .fp_op_trap_type(ty), .fp_op_cexc(cx), .fp_op_trap_bit(bt), .ovf_event(ovf),
        .flush_denormal_mode(fl), .fp_inexact_trap_en(te), .counter_pair_select(sc), .upper_event_select(su),
        .lower_event_select(sl));
    psrb_pipe_model u_pipe (.clk(clk), .rd_en(rd_en), .rd_sel(rd_sel), .wr_en(wr_en), .wr_sel(wr_sel),
        .wr_data(wr_data), .fp_load_commit(ld), .fp_op_commit(op), .fp_op_trap_type(ty), .fp_op_cexc(cx),
        .fp_op_trap_bit(bt));
    initial forever #2 clk = ~clk;
    // faults are combinational, so catch them at the taking edge
    always @(posedge clk) if (rd_en) rpf <= rdf;
    always @(posedge clk) if (wr_en) wpf <= wrf;
    task automatic check(input logic [63:0] g, input logic [63:0] e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, g, e);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic pc_wr(input logic [63:0] d);
        u_pipe.req(1'b1, 3'h4, d, 1'b0, 1'b0, 3'h0, 5'h00, 3'h0);
    endtask
    task automatic fp_case(input logic l, input logic [2:0] t, input logic [4:0] c, input logic [2:0] b,
                           input logic [4:0] e);
        u_pipe.req(l, 3'h0, {59'h0, e}, l, 1'b1, t, c, b);
        u_pipe.rd(3'h0);
        check({59'h0, rd_data[4:0]}, {59'h0, e});
    endtask
    initial begin
        repeat (2000) @(posedge clk);
        bad_count++;
        finish_test();
    end
    initial begin
        sup = 1'b1;
        ovf = 8'h00;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            // fp state rows are written with a committing load, so current exceptions also come from the data
            u_pipe.req(1'b1, R_SEL[i], R_WD[i], R_SEL[i] == 3'h0, 1'b0, 3'h0, 5'h00, 3'h0);
            u_pipe.rd(R_SEL[i]);
            check(rd_data, R_EX[i]);
        end
        check({47'h0, fl, te, sc, su, sl}, {47'h0, 2'h3, 3'h2, 6'h15, 6'h2A});
        fp_case(1'b0, 3'h0, 5'h0A, 3'h0, 5'h0A);
        fp_case(1'b0, 3'h1, 5'h03, 3'h4, 5'h10);
        fp_case(1'b0, 3'h2, 5'h1F, 3'h0, 5'h10);
        fp_case(1'b0, 3'h3, 5'h1F, 3'h2, 5'h10);
        fp_case(1'b1, 3'h0, 5'h1F, 3'h0, 5'h05);
        check({63'h0, fl}, 64'h0);
        u_pipe.rd(3'h1);
        t0 = rd_data;
        u_pipe.rd(3'h1);
        check({1'b0, rd_data[62:0] - t0[62:0]}, 64'h2);
        u_pipe.req(1'b1, 3'h1, 64'h7FFF_FFFF_FFFF_FFFF, 1'b0, 1'b0, 3'h0, 5'h00, 3'h0);
        u_pipe.rd(3'h1);
        check({63'h0, rd_data < 64'h8}, 64'h1);
        @(posedge clk) sup <= 1'b0;
        u_pipe.rd(3'h4);
        check({63'h0, rpf}, 64'h0);
        pc_wr(64'h0000_0000_0000_0001);
        check({63'h0, wpf}, 64'h1);
        u_pipe.rd(3'h4);
        check({63'h0, rd_data[0]}, 64'h0);
        @(posedge clk) sup <= 1'b1;
        pc_wr(64'h0000_0000_0000_0001);
        @(posedge clk) sup <= 1'b0;
        u_pipe.rd(3'h4);
        check({63'h0, rpf}, 64'h1);
        check(rd_data, 64'h0);
        pc_wr(64'h0000_0000_0000_0000);
        check({63'h0, wpf}, 64'h1);
        @(posedge clk) sup <= 1'b1;
        pc_wr(64'h0000_0000_0000_0000);
        @(posedge clk) ovf <= 8'h04;
        @(posedge clk) ovf <= 8'h00;
        u_pipe.rd(3'h4);
        check(rd_data, 64'h0000_0004_00C0_0000);
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        u_pipe.rd(3'h4);
        check(rd_data, 64'h0000_0000_00C0_0000);
        finish_test();
    end
endmodule
